// ---- rtl/acls_pkg.sv ----
package acls_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ACLS_ADDR_AUDIO_CFG   = 8'h55;
    localparam logic [7:0] ACLS_ADDR_LINK_STATUS = 8'h5a;

    localparam logic [7:0] ACLS_AUDIO_CFG_RESET  = 8'h0c;
    localparam logic [7:0] ACLS_AUDIO_CFG_WMASK  = 8'hcf;
    localparam logic [7:0] ACLS_STATUS_RESET     = 8'h00;
    localparam logic [7:0] ACLS_UNMAPPED_READ    = 8'h00;

    // ------------------------------------------------------------
    // Audio routing config fields
    // ------------------------------------------------------------
    localparam int ACLS_CFG_TDM_TO_PARALLEL   = 7;
    localparam int ACLS_CFG_HDMI_I2S_OUT      = 6;
    localparam int ACLS_CFG_FLUSH_ON_TYPE     = 3;
    localparam int ACLS_CFG_FLUSH_ON_AUD_SUM  = 2;
    localparam int ACLS_CFG_FLUSH_ON_VID_SUM  = 1;
    localparam int ACLS_CFG_FLUSH_ON_CLK_REGN = 0;

    // ------------------------------------------------------------
    // Downstream link status fields
    // ------------------------------------------------------------
    localparam int ACLS_STS_LINK_READY  = 7;
    localparam int ACLS_STS_TX_LOCKED   = 6;
    localparam int ACLS_STS_PORT_HI     = 5;
    localparam int ACLS_STS_PORT_LO     = 4;
    localparam int ACLS_STS_DATA_VALID  = 3;
    localparam int ACLS_STS_PLL_LOCK    = 2;
    localparam int ACLS_STS_NO_CLOCK    = 1;
    localparam int ACLS_STS_FREQ_SETTLE = 0;

    localparam logic [1:0] ACLS_PORT_NONE   = 2'h0;
    localparam logic [1:0] ACLS_PORT_SINGLE = 2'h1;

    // Audio source select: HDMI or local I2S pins
    localparam logic ACLS_SRC_HDMI  = 1'b0;
    localparam logic ACLS_SRC_LOCAL = 1'b1;

endpackage : acls_pkg

// ---- rtl/acls_audio_link_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Config bit 7 set enables the TDM-to-parallel audio converter.
// - With conversion on, link audio advances on the converter's clock.
// - Config bit 6 set drives received HDMI I2S audio onto the I2S pins.
// - HDMI I2S output is ignored unless audio source selects HDMI.
// - Config bit 3 set flushes audio FIFO when audio type changes.
// - Config bit 2 set flushes audio FIFO when audio infoframe checksum changes.
// - Config bit 1 set flushes audio FIFO when video infoframe checksum changes.
// - Config bit 0 set flushes audio FIFO when regeneration N or CTS changes.
// - Status bit 7 only once downstream connection valid and capabilities known.
// - Status bit 6 means transmitter active and far receiver locked.
// - Status bit 6 needs valid input and a correct port mode first.
// - Bits 5:4 report port mode while bit 6 set; 01 is single port 0.
// - Status bit 3 set while valid TMDS data is recovered.
// - Status bit 2 set while HDMI PLL is locked.
// - Status bit 0 set once input clock frequency is stable.
// - Audio source 0 sends HDMI audio, 1 sends local I2S pin audio.
module acls_audio_link_regs
    import acls_pkg::*;
#(
    parameter int SAMPLE_W   = 32,
    parameter int FIFO_DEPTH = 8,
    parameter int TYPE_W     = 4,
    parameter int SUM_W      = 8,
    parameter int ACR_W      = 20
)(
    input  wire logic                clk,                 // Core clock, 125 MHz
    input  wire logic                rst_n,               // Synchronous reset
    // Register port
    input  wire logic [7:0]          reg_addr,            // Register offset
    input  wire logic                reg_wr_en,           // Write strobe
    input  wire logic [7:0]          reg_wdata,           // Write data
    input  wire logic                reg_rd_en,           // Read strobe
    output logic      [7:0]          reg_rdata,           // Read data
    output logic                     reg_rd_valid,        // Read data valid
    // Audio source select from bridge config
    input  wire logic                audio_source_sel,    // 0 HDMI, 1 local
    // HDMI packet events
    input  wire logic                audio_type_valid,    // New audio type seen
    input  wire logic [TYPE_W-1:0]   audio_type,          // Audio type code
    input  wire logic                aud_frame_valid,     // Audio infoframe seen
    input  wire logic [SUM_W-1:0]    aud_frame_sum,       // Its checksum
    input  wire logic                vid_frame_valid,     // Video infoframe seen
    input  wire logic [SUM_W-1:0]    vid_frame_sum,       // Its checksum
    input  wire logic                clk_regen_valid,     // Regeneration packet seen
    input  wire logic [ACR_W-1:0]    clk_regen_n,         // N field
    input  wire logic [ACR_W-1:0]    clk_regen_cts,       // CTS field
    // Audio samples
    input  wire logic                hdmi_sample_valid,   // HDMI I2S sample strobe
    input  wire logic [SAMPLE_W-1:0] hdmi_sample_data,    // HDMI I2S sample
    input  wire logic                local_sample_valid,  // Local pin sample strobe
    input  wire logic [SAMPLE_W-1:0] local_sample_data,   // Local pin sample
    input  wire logic                tdm_conv_tick,       // Converter clock tick
    input  wire logic                link_audio_ready,    // Link takes a sample
    output logic                     tdm_conv_en,         // Converter enable
    output logic                     link_audio_valid,    // Sample to link
    output logic      [SAMPLE_W-1:0] link_audio_data,     // Sample data to link
    output logic                     audio_fifo_flush,    // FIFO flushed this cycle
    output logic                     i2s_out_en,          // I2S pins driven
    output logic                     i2s_out_valid,       // I2S out sample strobe
    output logic      [SAMPLE_W-1:0] i2s_out_data,        // I2S out sample
    // Link and receiver state
    input  wire logic                link_caps_known,     // Connection and caps found
    input  wire logic                tx_active,           // Serial transmitter on
    input  wire logic                rx_locked,           // Far receiver locked
    input  wire logic                input_detected,      // Valid input seen
    input  wire logic [1:0]          port_mode,           // Entered port mode
    input  wire logic                input_data_valid,    // TMDS data recovered
    input  wire logic                hdmi_pll_locked,     // HDMI PLL lock
    input  wire logic                tmds_clk_present,    // Input clock present
    input  wire logic                input_freq_settled   // Frequency stable
);

    localparam int PTR_W = $clog2(FIFO_DEPTH);

    // ------------------------------------------------------------
    // Audio routing config register
    // ------------------------------------------------------------
    logic [7:0] audio_routing_config_reg;
    logic       cfg_write;

    // Shared by the write strobe and the read mux
    function automatic logic hits_cfg(input logic [7:0] addr);
        return addr == ACLS_ADDR_AUDIO_CFG;
    endfunction : hits_cfg

    assign cfg_write = reg_wr_en && hits_cfg(reg_addr);

    // Status register is read-only: no write path exists
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            audio_routing_config_reg <= ACLS_AUDIO_CFG_RESET;
        else if (cfg_write)
            audio_routing_config_reg <= reg_wdata & ACLS_AUDIO_CFG_WMASK;
    end

    logic tdm_on;
    logic i2s_fwd;
    assign tdm_on  = audio_routing_config_reg[ACLS_CFG_TDM_TO_PARALLEL];
    assign i2s_fwd = audio_routing_config_reg[ACLS_CFG_HDMI_I2S_OUT]
                     && (audio_source_sel == ACLS_SRC_HDMI);

    // ------------------------------------------------------------
    // Change detection on HDMI packet fields
    // ------------------------------------------------------------
    logic [TYPE_W-1:0]  last_type_reg;
    logic [SUM_W-1:0]   last_aud_sum_reg;
    logic [SUM_W-1:0]   last_vid_sum_reg;
    logic [ACR_W-1:0]   last_n_reg;
    logic [ACR_W-1:0]   last_cts_reg;
    logic [3:0]         seen_reg;
    logic               type_chg;
    logic               aud_chg;
    logic               vid_chg;
    logic               acr_chg;
    logic               flush_next;

    // First packet after reset only records, a change needs a previous value
    assign type_chg = audio_type_valid && seen_reg[0] && (audio_type != last_type_reg);
    assign aud_chg  = aud_frame_valid && seen_reg[1] && (aud_frame_sum != last_aud_sum_reg);
    assign vid_chg  = vid_frame_valid && seen_reg[2] && (vid_frame_sum != last_vid_sum_reg);
    assign acr_chg  = clk_regen_valid && seen_reg[3]
                      && ((clk_regen_n != last_n_reg) || (clk_regen_cts != last_cts_reg));

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            last_type_reg    <= '0;
            last_aud_sum_reg <= '0;
            last_vid_sum_reg <= '0;
            last_n_reg       <= '0;
            last_cts_reg     <= '0;
            seen_reg         <= 4'h0;
        end
        else
        begin
            if (audio_type_valid)
            begin
                last_type_reg <= audio_type;
                seen_reg[0]   <= 1'b1;
            end
            if (aud_frame_valid)
            begin
                last_aud_sum_reg <= aud_frame_sum;
                seen_reg[1]      <= 1'b1;
            end
            if (vid_frame_valid)
            begin
                last_vid_sum_reg <= vid_frame_sum;
                seen_reg[2]      <= 1'b1;
            end
            if (clk_regen_valid)
            begin
                last_n_reg   <= clk_regen_n;
                last_cts_reg <= clk_regen_cts;
                seen_reg[3]  <= 1'b1;
            end
        end
    end

    always_comb
    begin
        flush_next = 1'b0;
        if (type_chg && audio_routing_config_reg[ACLS_CFG_FLUSH_ON_TYPE])
            flush_next = 1'b1;
        if (aud_chg && audio_routing_config_reg[ACLS_CFG_FLUSH_ON_AUD_SUM])
            flush_next = 1'b1;
        if (vid_chg && audio_routing_config_reg[ACLS_CFG_FLUSH_ON_VID_SUM])
            flush_next = 1'b1;
        if (acr_chg && audio_routing_config_reg[ACLS_CFG_FLUSH_ON_CLK_REGN])
            flush_next = 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            audio_fifo_flush <= 1'b0;
        else
            audio_fifo_flush <= flush_next;
    end

    // ------------------------------------------------------------
    // Audio FIFO toward the downstream link
    // ------------------------------------------------------------
    logic [SAMPLE_W-1:0] fifo_mem [FIFO_DEPTH];
    logic [PTR_W-1:0]    wr_ptr_reg;
    logic [PTR_W-1:0]    rd_ptr_reg;
    logic [PTR_W:0]      count_reg;
    logic                src_valid;
    logic [SAMPLE_W-1:0] src_data;
    logic                push;
    logic                pop;
    logic                out_free;
    logic                advance;

    // Source choice for link audio
    assign src_valid = (audio_source_sel == ACLS_SRC_LOCAL) ? local_sample_valid
                                                            : hdmi_sample_valid;
    assign src_data  = (audio_source_sel == ACLS_SRC_LOCAL) ? local_sample_data
                                                            : hdmi_sample_data;

    // With TDM on, samples leave only on the converter's clock
    assign advance  = tdm_on ? tdm_conv_tick : 1'b1;
    assign out_free = !link_audio_valid || link_audio_ready;
    // Full FIFO or a flush cycle drops the incoming sample
    assign push     = src_valid && (count_reg != FIFO_DEPTH[PTR_W:0]) && !flush_next;
    assign pop      = (count_reg != '0) && out_free && advance && !flush_next;

    always_ff @(posedge clk)
    begin
        if (push)
            fifo_mem[wr_ptr_reg] <= src_data;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n || flush_next)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end
        else
        begin
            if (push)
                wr_ptr_reg <= (wr_ptr_reg == PTR_W'(FIFO_DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
            if (pop)
                rd_ptr_reg <= (rd_ptr_reg == PTR_W'(FIFO_DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
            if (push && !pop)
                count_reg <= count_reg + 1'b1;
            else if (pop && !push)
                count_reg <= count_reg - 1'b1;
        end
    end

    // Sample holds until the link takes it or a flush clears it
    always_ff @(posedge clk)
    begin
        if (!rst_n || flush_next)
        begin
            link_audio_valid <= 1'b0;
            link_audio_data  <= '0;
        end
        else if (pop)
        begin
            link_audio_valid <= 1'b1;
            link_audio_data  <= fifo_mem[rd_ptr_reg];
        end
        else if (link_audio_ready)
            link_audio_valid <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            tdm_conv_en <= 1'b0;
        else
            tdm_conv_en <= tdm_on;
    end

    // ------------------------------------------------------------
    // HDMI I2S output pins
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            i2s_out_en    <= 1'b0;
            i2s_out_valid <= 1'b0;
            i2s_out_data  <= '0;
        end
        else
        begin
            i2s_out_en    <= i2s_fwd;
            i2s_out_valid <= i2s_fwd && hdmi_sample_valid;
            if (i2s_fwd && hdmi_sample_valid)
                i2s_out_data <= hdmi_sample_data;
        end
    end

    // ------------------------------------------------------------
    // Downstream link status register
    // ------------------------------------------------------------
    logic [7:0] downstream_link_status_reg;
    logic [7:0] status_next;
    logic       tx_ok;

    assign tx_ok = tx_active && rx_locked && input_detected
                   && (port_mode != ACLS_PORT_NONE);

    // Port field reads 00 unless transmit status is set
    always_comb
    begin
        status_next = ACLS_STATUS_RESET;
        status_next[ACLS_STS_LINK_READY]   = link_caps_known;
        status_next[ACLS_STS_TX_LOCKED]    = tx_ok;
        if (tx_ok)
            status_next[ACLS_STS_PORT_HI:ACLS_STS_PORT_LO] = port_mode;
        status_next[ACLS_STS_DATA_VALID]   = input_data_valid;
        status_next[ACLS_STS_PLL_LOCK]     = hdmi_pll_locked;
        status_next[ACLS_STS_NO_CLOCK]     = !tmds_clk_present;
        status_next[ACLS_STS_FREQ_SETTLE]  = input_freq_settled;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
            downstream_link_status_reg <= ACLS_STATUS_RESET;
        else
            downstream_link_status_reg <= status_next;
    end

    // ------------------------------------------------------------
    // Register read path
    // ------------------------------------------------------------
    // Read data holds until the next read
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            reg_rdata    <= ACLS_UNMAPPED_READ;
            reg_rd_valid <= 1'b0;
        end
        else
        begin
            reg_rd_valid <= reg_rd_en;
            if (reg_rd_en)
            begin
                if (hits_cfg(reg_addr))
                    reg_rdata <= audio_routing_config_reg;
                else if (reg_addr == ACLS_ADDR_LINK_STATUS)
                    reg_rdata <= downstream_link_status_reg;
                else
                    reg_rdata <= ACLS_UNMAPPED_READ;
            end
        end
    end

endmodule : acls_audio_link_regs
`default_nettype wire

// ---- verification/acls_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
module acls_chk
    import acls_pkg::*;
(
    input wire logic       clk,                // Core clock
    input wire logic       rst_n,              // Sync reset
    input wire logic [7:0] reg_addr,           // Offset
    input wire logic       reg_wr_en,          // Write strobe
    input wire logic [7:0] reg_wdata,          // Write data
    input wire logic       reg_rd_en,          // Read strobe
    input wire logic [7:0] reg_rdata,          // Read data
    input wire logic       reg_rd_valid,       // Read valid
    input wire logic       audio_source_sel,   // Source select
    input wire logic       hdmi_sample_valid,  // HDMI sample
    input wire logic       tdm_conv_tick,      // Converter tick
    input wire logic       link_audio_ready,   // Link ready
    input wire logic       tdm_conv_en,        // Converter on
    input wire logic       link_audio_valid,   // Link valid
    input wire logic       audio_fifo_flush,   // Flush pulse
    input wire logic       i2s_out_en,         // I2S pins on
    input wire logic       i2s_out_valid,      // I2S sample
    input wire logic       link_caps_known,    // Caps found
    input wire logic       tx_active,          // Transmitter on
    input wire logic       rx_locked,          // Far end locked
    input wire logic       input_detected,     // Input seen
    input wire logic [1:0] port_mode           // Port mode
);
    logic tx_ok;
    logic rd_sts;
    logic wr_cfg;
    assign tx_ok = tx_active && rx_locked && input_detected && (port_mode != 2'h0);
    assign rd_sts = reg_rd_en && (reg_addr == ACLS_ADDR_LINK_STATUS);
    assign wr_cfg = reg_wr_en && (reg_addr == ACLS_ADDR_AUDIO_CFG);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_tdm_on: assert property (wr_cfg && reg_wdata[7] |-> ##[1:2] tdm_conv_en)
        else $error("converter enable missing");
    a_tdm_off: assert property (wr_cfg && !reg_wdata[7] |-> ##[1:2] !tdm_conv_en)
        else $error("converter enable stuck");
    a_i2s_src_gate: assert property (audio_source_sel |=> !i2s_out_en)
        else $error("i2s out on with local source");
    a_i2s_fwd: assert property (hdmi_sample_valid && i2s_out_en && !audio_source_sel |=> i2s_out_valid)
        else $error("i2s sample not forwarded");
    a_i2s_cause: assert property (i2s_out_valid |-> $past(hdmi_sample_valid))
        else $error("i2s sample without input");
    a_sts_ready: assert property (rd_sts |=> reg_rd_valid && reg_rdata[7] == $past(link_caps_known, 2))
        else $error("link ready bit wrong");
    a_sts_tx: assert property (rd_sts |=> reg_rdata[6] == $past(tx_ok, 2))
        else $error("tx locked bit wrong");
    a_sts_port: assert property (rd_sts |=> reg_rdata[5:4] == (reg_rdata[6] ? $past(port_mode, 2) : 2'h0))
        else $error("port field wrong");
    a_flush_clear: assert property (audio_fifo_flush |-> !link_audio_valid)
        else $error("sample survived flush");
    a_valid_hold: assert property (link_audio_valid && !link_audio_ready |=> link_audio_valid || audio_fifo_flush)
        else $error("link sample dropped");
    a_tdm_pace: assert property ($rose(link_audio_valid) && tdm_conv_en |-> $past(tdm_conv_tick) || $past(tdm_conv_tick, 2))
        else $error("link sample without tick");

    c_flush: cover property (audio_fifo_flush);
    c_rd_sts: cover property (rd_sts);
    c_i2s: cover property (i2s_out_valid);
endmodule : acls_chk

bind acls_audio_link_regs acls_chk u_chk (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .audio_source_sel(audio_source_sel),
    .hdmi_sample_valid(hdmi_sample_valid), .tdm_conv_tick(tdm_conv_tick),
    .link_audio_ready(link_audio_ready), .tdm_conv_en(tdm_conv_en),
    .link_audio_valid(link_audio_valid), .audio_fifo_flush(audio_fifo_flush),
    .i2s_out_en(i2s_out_en), .i2s_out_valid(i2s_out_valid), .link_caps_known(link_caps_known),
    .tx_active(tx_active), .rx_locked(rx_locked), .input_detected(input_detected),
    .port_mode(port_mode));
`default_nettype wire

// ---- verification/acls_link_sink.sv ----
`timescale 1ns/100ps
`default_nettype none
module acls_link_sink (
    input  wire logic        clk,    // Core clock
    input  wire logic        rst_n,  // Sync reset
    input  wire logic        valid,  // Sample offered
    input  wire logic [31:0] data,   // Sample data
    input  wire logic        stall,  // Hold off
    input  wire logic        slow,   // Every other cycle
    output logic             ready,  // Taking samples
    output logic      [15:0] cnt,    // Samples taken
    output logic      [31:0] last    // Last sample
);
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            ready <= 1'b0;
        else
            ready <= !stall && !(slow && ready);
    end
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            cnt <= 16'h0000;
        else if (valid && ready)
            cnt <= cnt + 16'h0001;
    end
    always_ff @(posedge clk)
    begin
        if (valid && ready)
            last <= data;
    end
endmodule : acls_link_sink
`default_nettype wire

// ---- verification/tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
    $display("wrong value t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_top
    import acls_pkg::*;
;
    logic        clk, rst_n, wr_en, rd_en, sel, t_v, af_v, vf_v, cr_v, hs_v, ls_v;
    logic        tick, stall, slow, rd_valid, ready, tdm_en, l_valid, flush, i2s_en, i2s_v;
    logic [7:0]  addr, wdata, rdata, a_sum, v_sum;
    logic [3:0]  a_type;
    logic [19:0] cts, crn;
    logic [31:0] hs_d, ls_d, l_data, i2s_d, last;
    logic [15:0] cnt;
    logic [9:0]  sts;
    int          checks = 0;
    int          num_errors = 0;
    logic [9:0]  pats [6] = '{10'h3df, 10'h1d0, 10'h192, 10'h1c2, 10'h15a, 10'h027};

    acls_audio_link_regs dut (.clk(clk), .rst_n(rst_n), .reg_addr(addr), .reg_wr_en(wr_en),
        .reg_wdata(wdata), .reg_rd_en(rd_en), .reg_rdata(rdata), .reg_rd_valid(rd_valid),
        .audio_source_sel(sel), .audio_type_valid(t_v), .audio_type(a_type),
        .aud_frame_valid(af_v), .aud_frame_sum(a_sum), .vid_frame_valid(vf_v),
        .vid_frame_sum(v_sum), .clk_regen_valid(cr_v), .clk_regen_n(crn),
        .clk_regen_cts(cts), .hdmi_sample_valid(hs_v), .hdmi_sample_data(hs_d),
        .local_sample_valid(ls_v), .local_sample_data(ls_d), .tdm_conv_tick(tick),
        .link_audio_ready(ready), .tdm_conv_en(tdm_en), .link_audio_valid(l_valid),
        .link_audio_data(l_data), .audio_fifo_flush(flush), .i2s_out_en(i2s_en),
        .i2s_out_valid(i2s_v), .i2s_out_data(i2s_d), .link_caps_known(sts[9]),
        .tx_active(sts[8]), .rx_locked(sts[7]), .input_detected(sts[6]), .port_mode(sts[5:4]),
        .input_data_valid(sts[3]), .hdmi_pll_locked(sts[2]), .tmds_clk_present(sts[1]),
        .input_freq_settled(sts[0]));
    acls_link_sink sink (.clk(clk), .rst_n(rst_n), .valid(l_valid), .data(l_data),
        .stall(stall), .slow(slow), .ready(ready), .cnt(cnt), .last(last));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr_en = 1'b1;
        step(1);
        wr_en = 1'b0;
        step(1);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        addr = a;
        rd_en = 1'b1;
        step(1);
        rd_en = 1'b0;
        `CHK(rd_valid, 1'b1)
        `CHK(rdata, e)
        step(1);
    endtask : rd

    task automatic ev(input int k, input logic [19:0] v);
        a_type = v[3:0];
        a_sum = v[7:0];
        v_sum = v[7:0];
        crn = v;
        {t_v, af_v, vf_v, cr_v} = 4'h8 >> k;
        step(1);
        {t_v, af_v, vf_v, cr_v} = 4'h0;
    endtask : ev

    function automatic logic [7:0] exp_sts(input logic [9:0] p);
        logic tx;
        tx = p[8] & p[7] & p[6] & (p[5:4] != 2'h0);
        return {p[9], tx, tx ? p[5:4] : 2'h0, p[3], p[2], ~p[1], p[0]};
    endfunction : exp_sts

    task automatic t_regs;
        rd(ACLS_ADDR_AUDIO_CFG, 8'h0c);
        rd(8'h56, 8'h00);
        wr(ACLS_ADDR_AUDIO_CFG, 8'hff);
        rd(ACLS_ADDR_AUDIO_CFG, 8'hcf);
        `CHK(tdm_en, 1'b1)
        `CHK(i2s_en, 1'b1)
        sel = 1'b1;
        step(2);
        `CHK(i2s_en, 1'b0)
        sel = 1'b0;
        wr(ACLS_ADDR_AUDIO_CFG, 8'h00);
        `CHK(tdm_en, 1'b0)
        wr(ACLS_ADDR_LINK_STATUS, 8'hff);
        rd(ACLS_ADDR_LINK_STATUS, 8'h00);
    endtask : t_regs

    task automatic t_status;
        for (int i = 0; i < 6; i++)
        begin
            sts = pats[i];
            step(1);
            rd(ACLS_ADDR_LINK_STATUS, exp_sts(pats[i]));
        end
        sts = 10'h002;
    endtask : t_status

    task automatic t_audio;
        logic [15:0] n0;
        n0 = cnt;
        slow = 1'b1;
        wr(ACLS_ADDR_AUDIO_CFG, 8'h40);
        hs_d = 32'ha5a50001;
        hs_v = 1'b1;
        step(1);
        hs_v = 1'b0;
        `CHK(i2s_v, 1'b1)
        `CHK(i2s_d, 32'ha5a50001)
        sel = 1'b1;
        step(6);
        `CHK(last, 32'ha5a50001)
        ls_d = 32'h5a5a0002;
        {hs_v, ls_v} = 2'h3;
        step(1);
        {hs_v, ls_v} = 2'h0;
        `CHK(i2s_v, 1'b0)
        step(6);
        `CHK(cnt, n0 + 16'h0002)
        `CHK(last, 32'h5a5a0002)
        sel = 1'b0;
        slow = 1'b0;
        wr(ACLS_ADDR_AUDIO_CFG, 8'h80);
        hs_d = 32'ha5a50003;
        hs_v = 1'b1;
        step(1);
        hs_v = 1'b0;
        step(6);
        `CHK(cnt, n0 + 16'h0002)
        tick = 1'b1;
        step(1);
        tick = 1'b0;
        step(4);
        `CHK(last, 32'ha5a50003)
        wr(ACLS_ADDR_AUDIO_CFG, 8'h00);
    endtask : t_audio

    task automatic t_flush;
        logic [15:0] n0;
        for (int k = 0; k < 4; k++)
        begin
            wr(ACLS_ADDR_AUDIO_CFG, 8'h08 >> k);
            ev(k, 20'h00005);
            step(1);
            ev(k, 20'h00005);
            `CHK(flush, 1'b0)
            stall = 1'b1;
            hs_v = 1'b1;
            step(3);
            hs_v = 1'b0;
            step(4);
            n0 = cnt;
            ev(k, 20'h0000a);
            `CHK(flush, 1'b1)
            `CHK(l_valid, 1'b0)
            stall = 1'b0;
            step(8);
            `CHK(cnt, n0)
            wr(ACLS_ADDR_AUDIO_CFG, 8'h00);
            ev(k, 20'h00003);
            `CHK(flush, 1'b0)
        end
        wr(ACLS_ADDR_AUDIO_CFG, 8'h01);
        cts = 20'h00044;
        ev(3, 20'h00003);
        `CHK(flush, 1'b1)
    endtask : t_flush

    task automatic report_and_stop;
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : report_and_stop

    initial
    begin
        rst_n = 1'b0;
        {wr_en, rd_en, sel, t_v, af_v, vf_v, cr_v, hs_v, ls_v, tick, stall, slow} = '0;
        {addr, wdata, a_sum, v_sum, a_type, cts, crn, hs_d, ls_d} = '0;
        sts = 10'h002;
        repeat (2) @(posedge clk);
        #1;
        rst_n = 1'b1;
        step(1);
        t_regs();
        t_status();
        t_audio();
        t_flush();
        report_and_stop();
    end

    initial
    begin
        repeat (5000) @(posedge clk);
        num_errors++;
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
